// ### fault_mon_pkg.sv
package fault_mon_pkg;

	// Register byte offsets (32-bit aligned words)
	localparam logic [7:0] CTRL_OFS       = 8'h00;
	localparam logic [7:0] THRESH_OFS     = 8'h04;
	localparam logic [7:0] STATUS_OFS     = 8'h08;
	localparam logic [7:0] TORQUE_OFS     = 8'h0C;
	localparam logic [7:0] ATQ_OFS        = 8'h10;

	// Control register fields
	localparam int CTL_DEGLITCH_BIT = 0;
	localparam int CTL_RETRY_BIT    = 1;
	localparam int CTL_CLEAR_BIT    = 2;
	localparam int CTL_STALL_EN_BIT = 3;
	localparam int CTL_REPORT_BIT   = 4;
	localparam int CTL_SCALE_BIT    = 5;
	localparam int CTL_LEARN_BIT    = 6;
	localparam int CTL_DECAY_LSB    = 8;
	localparam int CTL_WIDTH        = 11;
	localparam logic [10:0] CTL_RESET = 11'h000;

	// Status register fields
	localparam int ST_FAULT_BIT   = 0;
	localparam int ST_OC_BIT      = 1;
	localparam int ST_STALL_BIT   = 2;
	localparam int ST_BLOCKED_BIT = 3;
	localparam int ST_LEARN_BIT   = 4;
	localparam int ST_LS_LSB      = 8;
	localparam int ST_HS_LSB      = 12;

	localparam logic [2:0] DECAY_SMART_RIPPLE = 3'h7;

	localparam int TORQUE_W          = 16;
	localparam int SCALE_LIMIT       = 500;
	localparam int SCALE_SHIFT       = 3;
	localparam int AVG_DEPTH         = 4;
	localparam int LEARN_STEADY_HALF = 64;
	localparam int LEARN_STALL_HALF  = 32;
	localparam logic [15:0] THRESH_RESET = 16'h0000;

	// Timing in nanoseconds, converted at a 25 MHz clock
	localparam int CLK_PERIOD_NS   = 40;
	localparam int DEGLITCH_SHORT_NS = 1000;
	localparam int DEGLITCH_LONG_NS  = 2000;
	localparam int RETRY_NS          = 4000000;
	localparam int DEGLITCH_SHORT_CYC = (DEGLITCH_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DEGLITCH_LONG_CYC  = (DEGLITCH_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RETRY_CYC          = (RETRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : fault_mon_pkg

// ### host_model.sv
`timescale 1ns/1ps
`default_nettype none

module host_model (
	input  wire logic        clk_sys_i,
	input  wire logic        waitrequest_i,
	input  wire logic [31:0] readdata_i,
	output var logic  [7:0]  address_o,
	output var logic         read_o,
	output var logic         write_o,
	output var logic  [31:0] writedata_o
);
	initial begin
		address_o <= 8'h00;
		read_o <= 1'b0;
		write_o <= 1'b0;
		writedata_o <= 32'h0;
	end
	// No latency is assumed: the request stands until waitrequest is seen low
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		address_o <= a;
		writedata_o <= d;
		write_o <= 1'b1;
		do @(posedge clk_sys_i); while (waitrequest_i !== 1'b0);
		write_o <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys_i);
		address_o <= a;
		read_o <= 1'b1;
		do @(posedge clk_sys_i); while (waitrequest_i !== 1'b0);
		d = readdata_i;
		read_o <= 1'b0;
	endtask : rd
endmodule : host_model

`default_nettype wire

// ### osm_sva.sv
`timescale 1ns/1ps
`default_nettype none

module osm_checker #(
	parameter int RETRY_CYCLES = 20
) (
	input wire logic       clk_sys_i,
	input wire logic       sys_rst_i,
	input wire logic       avs_read_i,
	input wire logic       avs_write_i,
	input wire logic       avs_waitrequest_o,
	input wire logic [3:0] lowside_limit_i,
	input wire logic [3:0] highside_limit_i,
	input wire logic       sleep_low_input_i,
	input wire logic       serial_mode_i,
	input wire logic       other_fault_i,
	input wire logic       half_cycle_i,
	input wire logic       fault_alert_low_o,
	input wire logic       bridge_enable_o,
	input wire logic       charge_pump_on_o,
	input wire logic       stall_detected_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);
	logic       lim;
	logic       hc_prev_q;
	logic [7:0] lim_q, hc_q, clr_q;
	assign lim = (|lowside_limit_i) || (|highside_limit_i);
	// Ages saturate so a long run never wraps back into range
	always_ff @(posedge clk_sys_i) begin
		lim_q <= lim ? lim_q + {7'h00, lim_q != 8'hFF} : 8'h00;
	end
	always_ff @(posedge clk_sys_i) begin
		hc_prev_q <= half_cycle_i;
		if (sys_rst_i) begin
			hc_q <= 8'hFF;
			clr_q <= 8'hFF;
		end else begin
			hc_q <= (half_cycle_i != hc_prev_q) ? 8'h00 : hc_q + {7'h00, hc_q != 8'hFF};
			clr_q <= ((avs_write_i && !avs_waitrequest_o) || !sleep_low_input_i) ? 8'h00
				: clr_q + {7'h00, clr_q != 8'hFF};
		end
	end
	chk_bus_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
		|=> !avs_waitrequest_o) else $error("bus answer late");
	chk_wait_pulse: assert property ($fell(avs_waitrequest_o) |=> $rose(avs_waitrequest_o))
		else $error("waitrequest low too long");
	chk_oc_trip: assert property (lim_q == 8'h3C |-> !bridge_enable_o
		&& !fault_alert_low_o && charge_pump_on_o) else $error("overcurrent not tripped");
	chk_oc_deglitch: assert property ($fell(bridge_enable_o) && !other_fault_i
		&& sleep_low_input_i |-> lim_q >= 8'h19) else $error("trip before deglitch");
	chk_bridge_return: assert property ($rose(bridge_enable_o) |-> !lim && !$past(lim))
		else $error("bridge back while limit active");
	chk_stall_cause: assert property ($rose(stall_detected_o)
		|-> serial_mode_i && !other_fault_i) else $error("stall while detection off");
	chk_stall_edge: assert property ($rose(stall_detected_o) |-> hc_q <= 8'h08)
		else $error("stall away from zero crossing");
	chk_stall_clear: assert property ($fell(stall_detected_o) |-> clr_q <= 8'h08)
		else $error("stall dropped without clear");
	cover property ($rose(stall_detected_o));
	cover property ($fell(stall_detected_o));
	cover property ($fell(bridge_enable_o));
endmodule : osm_checker

bind overcurrent_stall_monitor osm_checker #(.RETRY_CYCLES(RETRY_CYCLES)) osm_checker_i (
	.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .avs_read_i(avs_read_i),
	.avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
	.lowside_limit_i(lowside_limit_i), .highside_limit_i(highside_limit_i),
	.sleep_low_input_i(sleep_low_input_i), .serial_mode_i(serial_mode_i),
	.other_fault_i(other_fault_i), .half_cycle_i(half_cycle_i),
	.fault_alert_low_o(fault_alert_low_o), .bridge_enable_o(bridge_enable_o),
	.charge_pump_on_o(charge_pump_on_o), .stall_detected_o(stall_detected_o)
);

`default_nettype wire

// ### overcurrent_stall_monitor.sv
// Functional notes
// - Persistent current limit faults, disables bridges, alerts
// - Overcurrent latches summary and overcurrent flags
// - Supply short sets lowside, ground short highside
// - Deglitch time selectable by control bit
// - Retry select bit picks latched or retry
// - Latched mode waits for clear or sleep
// - Retry mode re-enables after interval, condition gone
// - Stall detect needs serial, ripple decay, enable, nofault
// - Torque from rising versus falling off-times
// - Torque averages last four half-cycles
// - Below threshold stalls, latched at zero crossing
// - Stall latches stall, blocked and summary flags
// - Stall drives alert only with report enable
// - Stall flags clear only by clear or sleep
// - Scale bit multiplies counts below 500 by 8
// - Threshold written by host or by learning
// - Learn: 32 steady cycles, 16 stall cycles
// - Learned threshold is average of both counts
// - Auto-torque stall picks ceiling or floor
// - Clear or sleep pulse clears latched flags
`timescale 1ns/1ps
`default_nettype none

module overcurrent_stall_monitor
	import fault_mon_pkg::*;
#(
	parameter int RETRY_CYCLES = RETRY_CYC
) (
	input  wire logic        clk_sys_i,
	input  wire logic        sys_rst_i,
	// Avalon-MM slave
	input  wire logic [7:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output logic [31:0]      avs_readdata_o,
	output logic             avs_waitrequest_o,
	// Analog and system inputs
	input  wire logic [3:0]  lowside_limit_i,
	input  wire logic [3:0]  highside_limit_i,
	input  wire logic        sleep_low_input_i,
	input  wire logic        serial_mode_i,
	input  wire logic        other_fault_i,
	input  wire logic        autotorque_enable_i,
	input  wire logic        half_cycle_i,
	input  wire logic        rising_quadrant_i,
	input  wire logic [11:0] offtime_i,
	// Outputs
	output logic             fault_alert_low_o,
	output logic             bridge_enable_o,
	output logic             charge_pump_on_o,
	output logic             stall_detected_o,
	output logic [7:0]       coil_current_o
);

	typedef enum logic [2:0] {
		OC_IDLE  = 3'b001,
		OC_FAULT = 3'b010,
		OC_RETRY = 3'b100
	} oc_state_e;

	typedef enum logic [2:0] {
		LRN_IDLE   = 3'b001,
		LRN_STEADY = 3'b010,
		LRN_STALL  = 3'b100
	} learn_state_e;

	// Pin synchronisers
	logic [12:0] sync1_q;
	logic [12:0] sync2_q;
	logic [11:0] off1_q;
	logic [11:0] off2_q;
	logic        half_prev_q;

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			sync1_q <= '0;
			sync2_q <= '0;
			off1_q  <= '0;
			off2_q  <= '0;
			half_prev_q <= 1'b0;
		end else begin
			sync1_q <= {lowside_limit_i, highside_limit_i, serial_mode_i, other_fault_i,
			            half_cycle_i, sleep_low_input_i, rising_quadrant_i};
			sync2_q <= sync1_q;
			off1_q  <= offtime_i;
			off2_q  <= off1_q;
			half_prev_q <= sync2_q[2];
		end
	end

	logic [3:0] ls_lim;
	logic [3:0] hs_lim;
	logic       serial_s;
	logic       other_s;
	logic       half_s;
	logic       sleep_s;
	logic       rising_s;
	logic       half_edge;
	assign ls_lim   = sync2_q[12:9];
	assign hs_lim   = sync2_q[8:5];
	assign serial_s = sync2_q[4];
	assign other_s  = sync2_q[3];
	assign half_s   = sync2_q[2];
	assign sleep_s  = sync2_q[1];
	assign rising_s = sync2_q[0];
	assign half_edge = half_s ^ half_prev_q;

	// Sleep low-going pulse resets fault state
	logic sleep_rst;
	assign sleep_rst = ~sleep_s;

	// Registers
	logic [CTL_WIDTH-1:0] ctl_q;
	logic [15:0]          thresh_q;
	logic [15:0]          atq_q;
	logic                 clear_cmd;
	logic                 wr_ctl;
	logic                 wr_thr;
	logic                 wr_atq;
	logic                 learn_done_pulse;

	assign wr_ctl = avs_write_i & ~avs_waitrequest_o & (avs_address_i == CTRL_OFS);
	assign wr_thr = avs_write_i & ~avs_waitrequest_o & (avs_address_i == THRESH_OFS);
	assign wr_atq = avs_write_i & ~avs_waitrequest_o & (avs_address_i == ATQ_OFS);
	assign clear_cmd = (wr_ctl & avs_byteenable_i[0] & avs_writedata_i[CTL_CLEAR_BIT])
	                   | sleep_rst;

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			ctl_q <= CTL_RESET;
		end else if (wr_ctl) begin
			if (avs_byteenable_i[0])
				ctl_q[7:0] <= {1'b0, avs_writedata_i[6:3], 1'b0, avs_writedata_i[1:0]};
			if (avs_byteenable_i[1])
				ctl_q[10:8] <= avs_writedata_i[10:8];
		end else if (learn_done_pulse) begin
			ctl_q[CTL_LEARN_BIT] <= 1'b0;
		end
	end

	// Overcurrent deglitch and retry
	oc_state_e   oc_q;
	logic [26:0] oc_cnt_q;
	logic        oc_cond;
	logic [26:0] deglitch_cyc;
	assign oc_cond = |{ls_lim, hs_lim};
	assign deglitch_cyc = ctl_q[CTL_DEGLITCH_BIT] ? 27'(DEGLITCH_LONG_CYC)
	                                              : 27'(DEGLITCH_SHORT_CYC);

	logic oc_flag_q;
	logic [3:0] ls_flag_q;
	logic [3:0] hs_flag_q;
	logic oc_detect;
	assign oc_detect = (oc_q == OC_IDLE) && oc_cond && (oc_cnt_q >= deglitch_cyc - 27'd1);

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			oc_q     <= OC_IDLE;
			oc_cnt_q <= '0;
		end else begin
			case (oc_q)
				OC_IDLE: begin
					if (!oc_cond)
						oc_cnt_q <= '0;
					else if (oc_detect) begin
						oc_q     <= OC_FAULT;
						oc_cnt_q <= '0;
					end else
						oc_cnt_q <= oc_cnt_q + 27'd1;
				end
				OC_FAULT: begin
					if (ctl_q[CTL_RETRY_BIT]) begin
						oc_q     <= OC_RETRY;
						oc_cnt_q <= '0;
					end else if (!oc_cond && clear_cmd)
						oc_q <= OC_IDLE;
				end
				OC_RETRY: begin
					if (!ctl_q[CTL_RETRY_BIT])
						oc_q <= OC_FAULT;
					else if (oc_cond)
						oc_cnt_q <= '0;
					else if (oc_cnt_q >= 27'(RETRY_CYCLES) - 27'd1)
						oc_q <= OC_IDLE;
					else
						oc_cnt_q <= oc_cnt_q + 27'd1;
				end
				default: oc_q <= OC_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			oc_flag_q <= 1'b0;
			ls_flag_q <= '0;
			hs_flag_q <= '0;
		end else if (oc_detect) begin
			oc_flag_q <= 1'b1;
			ls_flag_q <= ls_flag_q | ls_lim;
			hs_flag_q <= hs_flag_q | hs_lim;
		end else if (clear_cmd) begin
			oc_flag_q <= 1'b0;
			ls_flag_q <= '0;
			hs_flag_q <= '0;
		end
	end

	// Torque metric
	logic        stall_en;
	logic [11:0] rise_off_q;
	logic [11:0] fall_off_q;
	logic [13:0] hist_q [AVG_DEPTH];
	logic [15:0] raw_sum;
	logic [15:0] raw_avg;
	logic [15:0] torque_q;
	logic [15:0] scaled;

	assign stall_en = serial_s && (ctl_q[10:8] == DECAY_SMART_RIPPLE)
	                  && ctl_q[CTL_STALL_EN_BIT] && (oc_q == OC_IDLE) && !other_s;

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			rise_off_q <= '0;
			fall_off_q <= '0;
		end else if (half_edge) begin
			rise_off_q <= '0;
			fall_off_q <= '0;
		end else if (rising_s) begin
			rise_off_q <= off2_q;
		end else begin
			fall_off_q <= off2_q;
		end
	end

	always_comb begin
		raw_sum = '0;
		for (int i = 0; i < AVG_DEPTH; i++)
			raw_sum = raw_sum + 16'(hist_q[i]);
		raw_avg = raw_sum >> 2;
	end

	logic [13:0] half_diff;
	assign half_diff = (fall_off_q > rise_off_q) ? 14'(fall_off_q - rise_off_q) : 14'd0;

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			for (int i = 0; i < AVG_DEPTH; i++)
				hist_q[i] <= '0;
		end else if (half_edge) begin
			hist_q[0] <= half_diff;
			for (int i = 1; i < AVG_DEPTH; i++)
				hist_q[i] <= hist_q[i-1];
		end
	end

	assign scaled = (ctl_q[CTL_SCALE_BIT] && raw_avg < 16'(SCALE_LIMIT))
	                ? 16'(raw_avg << SCALE_SHIFT) : raw_avg;

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i)
			torque_q <= '0;
		else if (half_edge)
			torque_q <= scaled;
	end

	// Stall latch at zero crossing (half-cycle boundary)
	logic stall_q;
	logic stall_hit;
	assign stall_hit = stall_en && half_edge && (scaled < thresh_q);

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i)
			stall_q <= 1'b0;
		else if (stall_hit)
			stall_q <= 1'b1;
		else if (clear_cmd)
			stall_q <= 1'b0;
	end

	// Threshold learning
	learn_state_e lrn_q;
	logic [6:0]   lrn_cnt_q;
	logic [21:0]  steady_acc_q;
	logic [21:0]  stall_acc_q;
	logic         learn_ok_q;
	logic [15:0]  learned;
	// The last stall sample is still in flight at the done edge, so it is added here
	assign learned = 16'((steady_acc_q / LEARN_STEADY_HALF
	                 + (stall_acc_q + 22'(scaled)) / LEARN_STALL_HALF) >> 1);
	assign learn_done_pulse = (lrn_q == LRN_STALL) && half_edge
	                          && (lrn_cnt_q == 7'(LEARN_STALL_HALF - 1));

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			lrn_q        <= LRN_IDLE;
			lrn_cnt_q    <= '0;
			steady_acc_q <= '0;
			stall_acc_q  <= '0;
		end else begin
			case (lrn_q)
				LRN_IDLE: begin
					if (ctl_q[CTL_LEARN_BIT]) begin
						lrn_q        <= LRN_STEADY;
						lrn_cnt_q    <= '0;
						steady_acc_q <= '0;
						stall_acc_q  <= '0;
					end
				end
				LRN_STEADY: begin
					if (half_edge) begin
						steady_acc_q <= steady_acc_q + 22'(scaled);
						if (lrn_cnt_q == 7'(LEARN_STEADY_HALF - 1)) begin
							lrn_q     <= LRN_STALL;
							lrn_cnt_q <= '0;
						end else
							lrn_cnt_q <= lrn_cnt_q + 7'd1;
					end
				end
				LRN_STALL: begin
					if (half_edge) begin
						stall_acc_q <= stall_acc_q + 22'(scaled);
						lrn_cnt_q   <= lrn_cnt_q + 7'd1;
						if (learn_done_pulse)
							lrn_q <= LRN_IDLE;
					end
				end
				default: lrn_q <= LRN_IDLE;
			endcase
		end
	end

	// Learning succeeds only when a stalled motor reads clearly lower
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i)
			learn_ok_q <= 1'b0;
		else if (learn_done_pulse && (steady_acc_q / LEARN_STEADY_HALF
		         > 22'(stall_acc_q + 22'(scaled)) / LEARN_STALL_HALF))
			learn_ok_q <= 1'b1;
		else if (clear_cmd || (lrn_q == LRN_IDLE && ctl_q[CTL_LEARN_BIT]))
			learn_ok_q <= 1'b0;
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			thresh_q <= THRESH_RESET;
			atq_q    <= '0;
		end else begin
			if (wr_thr)
				thresh_q <= avs_writedata_i[15:0];
			else if (learn_done_pulse)
				thresh_q <= learned;
			if (wr_atq)
				atq_q <= avs_writedata_i[15:0];
		end
	end

	// Outputs
	logic fault_sum;
	assign fault_sum = oc_flag_q || stall_q;

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			fault_alert_low_o <= 1'b1;
			bridge_enable_o   <= 1'b0;
			charge_pump_on_o  <= 1'b0;
			stall_detected_o  <= 1'b0;
			coil_current_o    <= '0;
		end else begin
			fault_alert_low_o <= !((oc_q != OC_IDLE)
			                     || (stall_q && ctl_q[CTL_REPORT_BIT]));
			bridge_enable_o   <= (oc_q == OC_IDLE);
			charge_pump_on_o  <= 1'b1;
			stall_detected_o  <= stall_q;
			if (autotorque_enable_i && stall_q)
				coil_current_o <= ctl_q[CTL_STALL_EN_BIT] ? atq_q[15:8] : atq_q[7:0];
			else
				coil_current_o <= atq_q[7:0];
		end
	end

	// Avalon slave: one wait cycle per access
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o    <= '0;
		end else begin
			avs_waitrequest_o <= !((avs_read_i || avs_write_i) && avs_waitrequest_o);
			if (avs_read_i && avs_waitrequest_o) begin
				if (avs_address_i == CTRL_OFS)
					avs_readdata_o <= 32'(ctl_q);
				else if (avs_address_i == THRESH_OFS)
					avs_readdata_o <= {16'h0000, thresh_q};
				else if (avs_address_i == STATUS_OFS)
					avs_readdata_o <= {16'h0000, hs_flag_q, ls_flag_q, 3'h0, learn_ok_q,
					                   stall_q, stall_q, oc_flag_q, fault_sum};
				else if (avs_address_i == TORQUE_OFS)
					avs_readdata_o <= {16'h0000, torque_q};
				else if (avs_address_i == ATQ_OFS)
					avs_readdata_o <= {16'h0000, atq_q};
				else
					avs_readdata_o <= 32'h0000_0000;
			end
		end
	end

endmodule : overcurrent_stall_monitor

`default_nettype wire

// ### testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench import fault_mon_pkg::*;;
	logic        clk_sys = 1'b0;
	logic        sys_rst, sleep_low, serial_mode, other_fault, atq_en, half_cyc, rise_quad;
	logic        alert_low, bridge_en, pump_on, stalled, av_rd, av_wr, av_wait;
	logic [3:0]  ls_lim, hs_lim;
	logic [11:0] offtime;
	logic [7:0]  coil, av_addr;
	logic [31:0] av_wdata, av_rdata, rdat;
	int          fails = 0;
	int          num_checks = 0;

	always #20 clk_sys = ~clk_sys;

	overcurrent_stall_monitor #(.RETRY_CYCLES(20)) overcurrent_stall_monitor_i (
		.clk_sys_i(clk_sys), .sys_rst_i(sys_rst), .avs_address_i(av_addr),
		.avs_read_i(av_rd), .avs_write_i(av_wr), .avs_writedata_i(av_wdata),
		.avs_byteenable_i(4'hF), .avs_readdata_o(av_rdata), .avs_waitrequest_o(av_wait),
		.lowside_limit_i(ls_lim), .highside_limit_i(hs_lim), .sleep_low_input_i(sleep_low),
		.serial_mode_i(serial_mode), .other_fault_i(other_fault), .autotorque_enable_i(atq_en),
		.half_cycle_i(half_cyc), .rising_quadrant_i(rise_quad), .offtime_i(offtime),
		.fault_alert_low_o(alert_low), .bridge_enable_o(bridge_en), .charge_pump_on_o(pump_on),
		.stall_detected_o(stalled), .coil_current_o(coil)
	);
	host_model host_model_i (
		.clk_sys_i(clk_sys), .waitrequest_i(av_wait), .readdata_i(av_rdata),
		.address_o(av_addr), .read_o(av_rd), .write_o(av_wr), .writedata_o(av_wdata)
	);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic chk1(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask : chk1
	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : wt
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		host_model_i.wr(a, d);
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		host_model_i.rd(a, rdat);
		chk(rdat, exp);
	endtask : rdc
	// Off time is falling minus rising per half cycle, then a zero crossing
	task automatic run_half(input int n, input logic [11:0] rise_t, input logic [11:0] fall_t);
		repeat (n) begin
			rise_quad <= 1'b1;
			offtime <= rise_t;
			wt(8);
			rise_quad <= 1'b0;
			offtime <= fall_t;
			wt(8);
			half_cyc <= ~half_cyc;
		end
		wt(8);
	endtask : run_half
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : print_verdict

	task automatic t_oc_latched;
		rdc(CTRL_OFS, 32'h0);
		rdc(8'h14, 32'h0);
		wr(CTRL_OFS, 32'h0);
		ls_lim <= 4'h2;
		hs_lim <= 4'h1;
		wt(40);
		chk1(bridge_en, 1'b0);
		chk1(alert_low, 1'b0);
		chk1(pump_on, 1'b1);
		ls_lim <= 4'h0;
		hs_lim <= 4'h0;
		wt(60);
		chk1(bridge_en, 1'b0);
		rdc(STATUS_OFS, 32'h1203);
		wr(CTRL_OFS, 32'h4);
		wt(6);
		chk1(bridge_en, 1'b1);
		rdc(STATUS_OFS, 32'h0);
	endtask : t_oc_latched
	task automatic t_oc_retry;
		wr(CTRL_OFS, 32'h3);
		repeat (2) begin
			ls_lim <= 4'h8;
			wt(30);
			ls_lim <= 4'h0;
			wt(2);
		end
		ls_lim <= 4'h8;
		wt(35);
		chk1(bridge_en, 1'b1);
		wt(30);
		chk1(bridge_en, 1'b0);
		ls_lim <= 4'h0;
		wt(40);
		chk1(bridge_en, 1'b1);
		chk1(alert_low, 1'b1);
		wr(CTRL_OFS, 32'h4);
	endtask : t_oc_retry
	task automatic t_stall;
		serial_mode <= 1'b1;
		atq_en <= 1'b1;
		wr(THRESH_OFS, 32'h64);
		wr(ATQ_OFS, 32'hA05A);
		// Detection stays off until the average has filled, else a false stall latches
		wr(CTRL_OFS, 32'h710);
		run_half(6, 12'h064, 12'h12C);
		rdc(TORQUE_OFS, 32'hC8);
		wr(CTRL_OFS, 32'h738);
		run_half(1, 12'h064, 12'h12C);
		rdc(TORQUE_OFS, 32'h640);
		wr(CTRL_OFS, 32'h718);
		run_half(2, 12'h064, 12'h08C);
		chk1(stalled, 1'b0);
		run_half(2, 12'h064, 12'h08C);
		chk1(stalled, 1'b1);
		chk1(alert_low, 1'b0);
		chk({24'h0, coil}, 32'hA0);
		rdc(STATUS_OFS, 32'hD);
		sleep_low <= 1'b0;
		wt(8);
		sleep_low <= 1'b1;
		wt(4);
		chk1(stalled, 1'b0);
		wr(CTRL_OFS, 32'h708);
		run_half(2, 12'h064, 12'h08C);
		chk1(stalled, 1'b1);
		chk1(alert_low, 1'b1);
		wr(CTRL_OFS, 32'h700);
		wt(2);
		chk({24'h0, coil}, 32'h5A);
		wr(CTRL_OFS, 32'h70C);
		wt(4);
		chk1(stalled, 1'b0);
		chk({24'h0, coil}, 32'h5A);
		other_fault <= 1'b1;
		run_half(2, 12'h064, 12'h08C);
		chk1(stalled, 1'b0);
		other_fault <= 1'b0;
	endtask : t_stall
	task automatic t_learn;
		wr(THRESH_OFS, 32'h0);
		wr(CTRL_OFS, 32'h718);
		run_half(4, 12'h064, 12'h190);
		wr(CTRL_OFS, 32'h758);
		run_half(64, 12'h064, 12'h190);
		run_half(32, 12'h064, 12'h0C8);
		host_model_i.rd(STATUS_OFS, rdat);
		chk1(rdat[ST_LEARN_BIT], 1'b1);
		// Steady average 300, stall samples 300 250 200 150 then 28 of 100
		rdc(THRESH_OFS, 32'hCF);
		rdc(CTRL_OFS, 32'h718);
	endtask : t_learn

	initial begin
		wt(10000);
		fails++;
		print_verdict();
	end
	initial begin
		sys_rst <= 1'b1;
		ls_lim <= 4'h0;
		hs_lim <= 4'h0;
		sleep_low <= 1'b1;
		serial_mode <= 1'b0;
		other_fault <= 1'b0;
		atq_en <= 1'b0;
		half_cyc <= 1'b0;
		rise_quad <= 1'b0;
		offtime <= 12'h000;
		wt(12);
		sys_rst <= 1'b0;
		t_oc_latched();
		t_oc_retry();
		t_stall();
		t_learn();
		print_verdict();
	end
endmodule : testbench

`default_nettype wire
